//--- fwps_defs.svh
// Constants for the flash write-protect and security block.
// Assumes the includer is compiled after this header; definitions only.
// Overview of operation
// - Modify needs write enable; erase needs both
// - Both enables: external write erases whole page
// - Write enable routes external writes to flash
// - Unlock only by first then second key
// - Bad key or early operation disables until reset
// - Key register reads lock state in bits 1:0
// - Upper lock nibble cleared bans debug write/erase
// - Lower lock nibble cleared bans all debug access except device erase
// - Only debug device erase clears locks
// - Debug: any lock bars write/erase; unlocked pages readable while lower nibble set, locked/reserved refused
// - Debug reads lock byte only when nothing locked
// - Debug touches lock page only when unlocked
// - Unlocked code: locked/reserved/lock-page erase reset
// - Locked code: all pages, except lock erase/reserved
// - Lock byte is last user byte; 512-byte pages
// - One-shot bit: 3-cycle sense pulse (50 ns rounded up), else cycle
// - Data written by external writes, read by code reads
// - Flash error reset raises flash error flag
// - Key state relocks after each firmware write or erase
// - Byte write only clears bits; erase gives ones
// - Write enable stays set until software clears
`ifndef FWPS_DEFS_SVH
`define FWPS_DEFS_SVH

`define FWPS_PROGRAM_STORE_CONTROL_ADDR 8'h8f
`define FWPS_SCALE_ADDR 8'hb6
`define FWPS_KEY_ADDR 8'hb7
`define FWPS_PROGRAM_STORE_CONTROL_RST 8'h00
`define FWPS_SCALE_RST 8'h80
`define FWPS_KEY_RST 8'h00
`define FWPS_WE_BIT 0
`define FWPS_EE_BIT 1
`define FWPS_READ_ONESHOT_ENABLE_BIT 7
`define FWPS_KEY_FIRST 8'ha5
`define FWPS_KEY_SECOND 8'hf1
`define FWPS_KS_LOCKED 2'b00
`define FWPS_KS_FIRST 2'b01
`define FWPS_KS_OPEN 2'b10
`define FWPS_KS_DEAD 2'b11
`define FWPS_ADDR_W 13
`define FWPS_PAGE_W 9
`define FWPS_LOCK_ADDR 13'h1dff
`define FWPS_RSV_BASE 13'h1e00
`define FWPS_ERASED 8'hff
`define FWPS_CLK_MHZ 50
`define FWPS_ONESHOT_NS 50
`define FWPS_ONESHOT_CYC ((`FWPS_ONESHOT_NS * `FWPS_CLK_MHZ + 999) / 1000)

`endif

//--- fwps_pkg.sv
// Types shared by the flash write-protect and security block.
// Assumes fwps_defs.svh is on the include path.
`include "fwps_defs.svh"

package fwps_pkg;

   typedef enum logic [5:0] {
      FWPS_S_BOOT = 6'b000001,
      FWPS_S_IDLE = 6'b000010,
      FWPS_S_RDOLD = 6'b000100,
      FWPS_S_PROG = 6'b001000,
      FWPS_S_ERASE = 6'b010000,
      FWPS_S_READ = 6'b100000
   } fwps_state_e_t;

   typedef enum logic [1:0] {
      FWPS_K_LOCKED = `FWPS_KS_LOCKED,
      FWPS_K_FIRST = `FWPS_KS_FIRST,
      FWPS_K_OPEN = `FWPS_KS_OPEN,
      FWPS_K_DEAD = `FWPS_KS_DEAD
   } fwps_key_t;

   typedef enum logic [1:0] {
      FWPS_OP_READ = 2'h0,
      FWPS_OP_PROG = 2'h1,
      FWPS_OP_ERASE = 2'h2,
      FWPS_OP_ERASE_ALL = 2'h3
   } fwps_op_t;

   typedef enum logic [1:0] {
      FWPS_DBG_READ = 2'h0,
      FWPS_DBG_WRITE = 2'h1,
      FWPS_DBG_ERASE = 2'h2,
      FWPS_DBG_DEV_ERASE = 2'h3
   } fwps_dbg_cmd_t;

   typedef enum logic [1:0] {
      FWPS_SRC_CPU_WR = 2'h0,
      FWPS_SRC_CPU_RD = 2'h1,
      FWPS_SRC_DBG = 2'h2
   } fwps_src_t;

   // Command to the flash array macro, held until its done pulse
   typedef struct packed {
      logic req;
      fwps_op_t op;
      logic [`FWPS_ADDR_W-1:0] addr;
      logic [7:0] data;
   } fwps_flash_req_t;

   // Debug port request, one-cycle pulse
   typedef struct packed {
      logic req;
      fwps_dbg_cmd_t cmd;
      logic [`FWPS_ADDR_W-1:0] addr;
      logic [7:0] data;
   } fwps_dbg_req_t;

   // Debug port answer, one-cycle pulse
   typedef struct packed {
      logic done;
      logic ok;
      logic [7:0] data;
   } fwps_dbg_rsp_t;

endpackage

//--- fwps_sense_pulse.sv
// Flash read sense-amplifier enable generator.
// Assumes start_in is a one-cycle pulse on clk_in marking a read launch.
`timescale 1ns/1ns

module fwps_sense_pulse import fwps_pkg::*; #(
   parameter int ONESHOT_CYC = `FWPS_ONESHOT_CYC
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic start_in,
   input wire logic oneshot_in,
   output logic sense_en_out
);

   typedef struct packed {
      logic [7:0] cnt;
      logic en;
   } fwps_sense_st_t;

   fwps_sense_st_t st_r;
   fwps_sense_st_t st_nxt;

   initial begin
      if (ONESHOT_CYC < 1 || ONESHOT_CYC > 255) begin
         $error("fwps_sense_pulse: ONESHOT_CYC out of range");
      end
   end

   always_comb begin
      st_nxt = st_r;
      if (start_in) begin
         st_nxt.en = 1'b1;
         // One-shot length, or a single full cycle when disabled
         st_nxt.cnt = oneshot_in ? 8'(ONESHOT_CYC - 1) : 8'h00;
      end else if (st_r.cnt != 8'h00) begin
         st_nxt.cnt = st_r.cnt - 8'h01;
      end else begin
         st_nxt.en = 1'b0;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign sense_en_out = st_r.en;

endmodule // fwps_sense_pulse

//--- fwps_top.sv
// Flash write-protect, key lock and security controller.
// Assumes every requester runs on clk_in; requests are one-cycle pulses
// taken only while busy_out is low, and the flash macro answers each
// held command with a one-cycle done pulse.
`timescale 1ns/1ns

module fwps_top import fwps_pkg::*; #(
   parameter int ADDR_W = `FWPS_ADDR_W
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic sfr_wr_in,
   input wire logic sfr_rd_in,
   input wire logic [7:0] sfr_addr_in,
   input wire logic [7:0] sfr_wdata_in,
   output logic [7:0] sfr_rdata_out,
   input wire logic movx_wr_in,
   input wire logic [ADDR_W-1:0] movx_addr_in,
   input wire logic [7:0] movx_data_in,
   output logic xram_wr_out,
   output logic [ADDR_W-1:0] xram_addr_out,
   output logic [7:0] xram_data_out,
   input wire logic code_rd_in,
   input wire logic [ADDR_W-1:0] code_addr_in,
   input wire logic [ADDR_W-1:0] exec_pc_in,
   output logic cpu_done_out,
   output logic [7:0] code_rdata_out,
   output logic busy_out,
   input wire fwps_dbg_req_t dbg_req_in,
   output fwps_dbg_rsp_t dbg_rsp_out,
   output fwps_flash_req_t flash_req_out,
   input wire logic flash_done_in,
   input wire logic [7:0] flash_rdata_in,
   output logic flash_sense_out,
   output logic flash_error_reset_out,
   output logic flash_error_flag_out
);

   typedef struct packed {
      fwps_state_e_t fsm;
      fwps_key_t key;
      logic we;
      logic ee;
      logic read_oneshot_enable;
      logic [7:0] lock;
      fwps_src_t src;
      logic [7:0] wdata;
      fwps_flash_req_t fl;
      logic [7:0] rdata;
      logic xwr;
      logic [ADDR_W-1:0] xaddr;
      logic [7:0] xdata;
      logic cdone;
      logic [7:0] cdata;
      logic busy;
      fwps_dbg_rsp_t drsp;
      logic ferr_rst;
      logic ferr_flag;
      logic rd_start;
   } fwps_top_st_t;

   fwps_top_st_t st_r;
   fwps_top_st_t st_nxt;

   localparam logic [ADDR_W-1:0] LOCK_ADDR = `FWPS_LOCK_ADDR;
   localparam logic [ADDR_W-1:0] RSV_BASE = `FWPS_RSV_BASE;
   localparam logic [ADDR_W-1:0] PAGE_MASK =
      ~ADDR_W'((1 << `FWPS_PAGE_W) - 1);

   initial begin
      if (ADDR_W != `FWPS_ADDR_W) begin
         $error("fwps_top: ADDR_W must match the flash map");
      end
   end

   // Locked pages run from page 0 up to the complement of the lock byte
   function automatic logic pg_locked(input logic [ADDR_W-1:0] a,
                                      input logic [7:0] lk);
      logic [7:0] pg;
      pg = 8'(a[ADDR_W-1:`FWPS_PAGE_W]);
      pg_locked = (lk != `FWPS_ERASED) && (pg <= ~lk);
   endfunction

   function automatic logic same_pg(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] b);
      same_pg = (a & PAGE_MASK) == (b & PAGE_MASK);
   endfunction

   // Firmware access check; a failure forces a flash-error reset
   function automatic logic fw_fault(input logic [ADDR_W-1:0] t,
                                     input logic erase,
                                     input logic read,
                                     input logic [ADDR_W-1:0] pc,
                                     input logic [7:0] lk);
      logic run_locked;
      logic lock_rd;
      run_locked = pg_locked(pc, lk);
      lock_rd = read && (t == LOCK_ADDR);
      fw_fault = (t >= RSV_BASE)
         || (erase && same_pg(t, LOCK_ADDR))
         || (!run_locked && pg_locked(t, lk) && !lock_rd);
   endfunction

   logic sense_en;

   always_comb begin
      logic acc;
      logic dbg_ok;
      logic wr_ban;
      logic rd_ban;
      logic [ADDR_W-1:0] da;
      acc = 1'b0;
      dbg_ok = 1'b0;
      wr_ban = 1'b0;
      rd_ban = 1'b0;
      da = dbg_req_in.addr;
      st_nxt = st_r;
      st_nxt.xwr = 1'b0;
      st_nxt.cdone = 1'b0;
      st_nxt.drsp.done = 1'b0;
      st_nxt.ferr_rst = 1'b0;
      st_nxt.rd_start = 1'b0;

      // Register writes; enables persist until software clears them
      if (sfr_wr_in) begin
         case (sfr_addr_in)
            `FWPS_PROGRAM_STORE_CONTROL_ADDR: begin
               st_nxt.we = sfr_wdata_in[`FWPS_WE_BIT];
               st_nxt.ee = sfr_wdata_in[`FWPS_EE_BIT];
            end
            `FWPS_SCALE_ADDR: begin
               st_nxt.read_oneshot_enable = sfr_wdata_in[`FWPS_READ_ONESHOT_ENABLE_BIT];
            end
            `FWPS_KEY_ADDR: begin
               case (st_r.key)
                  FWPS_K_LOCKED: begin
                     st_nxt.key = (sfr_wdata_in == `FWPS_KEY_FIRST) ?
                        FWPS_K_FIRST : FWPS_K_DEAD;
                  end
                  FWPS_K_FIRST: begin
                     st_nxt.key = (sfr_wdata_in == `FWPS_KEY_SECOND) ?
                        FWPS_K_OPEN : FWPS_K_DEAD;
                  end
                  default: begin
                     // A further key write while open counts as wrong
                     st_nxt.key = FWPS_K_DEAD;
                  end
               endcase
            end
            default: begin
            end
         endcase
      end

      // Reads answer one cycle later; unmapped addresses read zero
      if (sfr_rd_in) begin
         case (sfr_addr_in)
            `FWPS_PROGRAM_STORE_CONTROL_ADDR: st_nxt.rdata = {6'h00, st_r.ee, st_r.we};
            `FWPS_SCALE_ADDR: st_nxt.rdata = {st_r.read_oneshot_enable, 7'h00};
            `FWPS_KEY_ADDR: st_nxt.rdata = {6'h00, st_r.key};
            default: st_nxt.rdata = 8'h00;
         endcase
      end

      case (st_r.fsm)
         FWPS_S_BOOT: begin
            // Fetch the lock byte before serving anyone
            if (!st_r.fl.req) begin
               st_nxt.fl = '{1'b1, FWPS_OP_READ, LOCK_ADDR, 8'h00};
               st_nxt.rd_start = 1'b1;
            end else if (flash_done_in) begin
               st_nxt.fl.req = 1'b0;
               st_nxt.lock = flash_rdata_in;
               st_nxt.busy = 1'b0;
               st_nxt.fsm = FWPS_S_IDLE;
            end
         end
         FWPS_S_IDLE: begin
            if (dbg_req_in.req) begin
               st_nxt.src = FWPS_SRC_DBG;
               wr_ban = (st_r.lock[7:4] != 4'hf)
                  || (st_r.lock[3:0] != 4'hf);
               rd_ban = (st_r.lock[3:0] != 4'hf)
                  || pg_locked(da, st_r.lock)
                  || ((da == LOCK_ADDR)
                      && (st_r.lock != `FWPS_ERASED));
               case (dbg_req_in.cmd)
                  FWPS_DBG_READ: begin
                     dbg_ok = !rd_ban && (da < RSV_BASE);
                     st_nxt.fl = '{1'b1, FWPS_OP_READ, da, 8'h00};
                  end
                  FWPS_DBG_WRITE: begin
                     // Clearing lock bits from here would add locks
                     dbg_ok = !wr_ban && (da < RSV_BASE)
                        && !((da == LOCK_ADDR)
                             && (dbg_req_in.data != `FWPS_ERASED));
                     st_nxt.fl = '{1'b1, FWPS_OP_READ, da, 8'h00};
                  end
                  FWPS_DBG_ERASE: begin
                     dbg_ok = !wr_ban && (da < RSV_BASE);
                     st_nxt.fl = '{1'b1, FWPS_OP_ERASE, da & PAGE_MASK,
                                   8'h00};
                  end
                  default: begin
                     dbg_ok = 1'b1;
                     st_nxt.fl = '{1'b1, FWPS_OP_ERASE_ALL, '0, 8'h00};
                  end
               endcase
               st_nxt.wdata = dbg_req_in.data;
               if (dbg_ok) begin
                  acc = 1'b1;
               end else begin
                  st_nxt.fl.req = 1'b0;
                  st_nxt.drsp = '{1'b1, 1'b0, 8'h00};
               end
            end else if (movx_wr_in && !st_r.we) begin
               // Write enable clear: the write belongs to data memory
               st_nxt.xwr = 1'b1;
               st_nxt.xaddr = movx_addr_in;
               st_nxt.xdata = movx_data_in;
            end else if (movx_wr_in) begin
               st_nxt.src = FWPS_SRC_CPU_WR;
               st_nxt.wdata = movx_data_in;
               if (st_r.key != FWPS_K_OPEN) begin
                  // Early attempt kills the key; flash untouched
                  st_nxt.key = FWPS_K_DEAD;
                  st_nxt.cdone = 1'b1;
               end else if (fw_fault(movx_addr_in, st_r.ee, 1'b0,
                                     exec_pc_in, st_r.lock)) begin
                  st_nxt.ferr_rst = 1'b1;
                  st_nxt.ferr_flag = 1'b1;
                  st_nxt.key = FWPS_K_LOCKED;
               end else if (st_r.ee) begin
                  // Data byte is ignored for an erase
                  st_nxt.fl = '{1'b1, FWPS_OP_ERASE,
                                movx_addr_in & PAGE_MASK, 8'h00};
                  acc = 1'b1;
               end else begin
                  st_nxt.fl = '{1'b1, FWPS_OP_READ, movx_addr_in,
                                8'h00};
                  acc = 1'b1;
               end
            end else if (code_rd_in) begin
               st_nxt.src = FWPS_SRC_CPU_RD;
               if (fw_fault(code_addr_in, 1'b0, 1'b1, exec_pc_in,
                            st_r.lock)) begin
                  st_nxt.ferr_rst = 1'b1;
                  st_nxt.ferr_flag = 1'b1;
               end else begin
                  st_nxt.fl = '{1'b1, FWPS_OP_READ, code_addr_in,
                                8'h00};
                  acc = 1'b1;
               end
            end
            if (acc) begin
               st_nxt.busy = 1'b1;
               case (st_nxt.fl.op)
                  FWPS_OP_READ: begin
                     st_nxt.rd_start = 1'b1;
                     st_nxt.fsm = (st_nxt.src == FWPS_SRC_CPU_RD
                        || (st_nxt.src == FWPS_SRC_DBG
                            && dbg_req_in.cmd == FWPS_DBG_READ)) ?
                        FWPS_S_READ : FWPS_S_RDOLD;
                  end
                  default: st_nxt.fsm = FWPS_S_ERASE;
               endcase
            end
         end
         FWPS_S_RDOLD: begin
            // Programming can only clear bits: merge with old contents
            if (flash_done_in) begin
               st_nxt.fl.op = FWPS_OP_PROG;
               st_nxt.fl.data = flash_rdata_in & st_r.wdata;
               st_nxt.fsm = FWPS_S_PROG;
            end
         end
         FWPS_S_PROG, FWPS_S_ERASE: begin
            if (flash_done_in) begin
               st_nxt.fl.req = 1'b0;
               st_nxt.busy = 1'b0;
               st_nxt.fsm = FWPS_S_IDLE;
               if (st_r.fl.op == FWPS_OP_ERASE_ALL) begin
                  st_nxt.lock = `FWPS_ERASED;
               end else if (st_r.fsm == FWPS_S_ERASE) begin
                  if (same_pg(st_r.fl.addr, LOCK_ADDR)) begin
                     st_nxt.lock = `FWPS_ERASED;
                  end
               end else if (st_r.fl.addr == LOCK_ADDR) begin
                  st_nxt.lock = st_r.fl.data;
               end
               if (st_r.src == FWPS_SRC_DBG) begin
                  st_nxt.drsp = '{1'b1, 1'b1, 8'h00};
               end else begin
                  st_nxt.cdone = 1'b1;
                  st_nxt.key = FWPS_K_LOCKED;
               end
            end
         end
         FWPS_S_READ: begin
            if (flash_done_in) begin
               st_nxt.fl.req = 1'b0;
               st_nxt.busy = 1'b0;
               st_nxt.fsm = FWPS_S_IDLE;
               if (st_r.src == FWPS_SRC_DBG) begin
                  st_nxt.drsp = '{1'b1, 1'b1, flash_rdata_in};
               end else begin
                  st_nxt.cdone = 1'b1;
                  st_nxt.cdata = flash_rdata_in;
               end
            end
         end
         default: begin
            st_nxt.fsm = FWPS_S_IDLE;
            st_nxt.fl.req = 1'b0;
            st_nxt.busy = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_r <= '0;
         st_r.fsm <= FWPS_S_BOOT;
         st_r.key <= fwps_key_t'(`FWPS_KEY_RST);
         st_r.we <= 1'(`FWPS_PROGRAM_STORE_CONTROL_RST >> `FWPS_WE_BIT);
         st_r.ee <= 1'(`FWPS_PROGRAM_STORE_CONTROL_RST >> `FWPS_EE_BIT);
         st_r.read_oneshot_enable <= 1'(`FWPS_SCALE_RST >> `FWPS_READ_ONESHOT_ENABLE_BIT);
         st_r.lock <= `FWPS_ERASED;
         st_r.busy <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   fwps_sense_pulse #(
      .ONESHOT_CYC(`FWPS_ONESHOT_CYC)
   ) u_sense (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .start_in(st_r.rd_start),
      .oneshot_in(st_r.read_oneshot_enable),
      .sense_en_out(sense_en)
   );

   assign sfr_rdata_out = st_r.rdata;
   assign xram_wr_out = st_r.xwr;
   assign xram_addr_out = st_r.xaddr;
   assign xram_data_out = st_r.xdata;
   assign cpu_done_out = st_r.cdone;
   assign code_rdata_out = st_r.cdata;
   assign busy_out = st_r.busy;
   assign dbg_rsp_out = st_r.drsp;
   assign flash_req_out = st_r.fl;
   assign flash_sense_out = sense_en;
   assign flash_error_reset_out = st_r.ferr_rst;
   assign flash_error_flag_out = st_r.ferr_flag;

endmodule // fwps_top

//--- fwps_flash_model.sv
// Behavioural flash array macro at the far side of the controller.
// Assumes one held command at a time; answer delay set by dly_in cycles.
`timescale 1ns/1ns

module fwps_flash_model import fwps_pkg::*; (
   input wire logic clk_in,
   input wire logic [3:0] dly_in,
   input wire fwps_flash_req_t req_in,
   output logic done_out,
   output logic [7:0] rdata_out
);
   logic [7:0] mem [0:8191];
   int cnt;

   // Nonvolatile: contents survive every controller reset
   initial begin
      done_out = 1'b0;
      rdata_out = 8'h00;
      cnt = 0;
      foreach (mem[i]) mem[i] = 8'hff;
   end

   always @(posedge clk_in) begin
      done_out <= 1'b0;
      rdata_out <= ~rdata_out;
      if (req_in.req && !done_out) begin
         if (cnt < dly_in) begin
            cnt <= cnt + 1;
         end else begin
            cnt <= 0;
            done_out <= 1'b1;
            case (req_in.op)
               FWPS_OP_READ: rdata_out <= mem[req_in.addr];
               FWPS_OP_PROG: mem[req_in.addr] <= req_in.data;
               FWPS_OP_ERASE: begin
                  for (int i = 0; i < 512; i++)
                     mem[{req_in.addr[12:9], 9'(i)}] <= 8'hff;
               end
               default: foreach (mem[i]) mem[i] <= 8'hff;
            endcase
         end
      end
   end
endmodule // fwps_flash_model

//--- fwps_top_assertions.sv
// Port-level checks of the flash protect controller.
// Assumes binding to fwps_top; enable mirrors follow register writes.
`timescale 1ns/1ns

module fwps_chk import fwps_pkg::*; (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic sfr_wr_in,
   input wire logic sfr_rd_in,
   input wire logic [7:0] sfr_addr_in,
   input wire logic [7:0] sfr_wdata_in,
   input wire logic [7:0] sfr_rdata_out,
   input wire logic movx_wr_in,
   input wire logic [7:0] movx_data_in,
   input wire logic xram_wr_out,
   input wire logic [7:0] xram_data_out,
   input wire logic busy_out,
   input wire fwps_dbg_req_t dbg_req_in,
   input wire fwps_dbg_rsp_t dbg_rsp_out,
   input wire fwps_flash_req_t flash_req_out,
   input wire logic flash_done_in,
   input wire logic flash_sense_out,
   input wire logic flash_error_reset_out,
   input wire logic flash_error_flag_out
);
   logic we_r;
   logic read_oneshot_enable_r;
   logic mv;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         we_r <= 1'b0;
         read_oneshot_enable_r <= 1'b1;
      end else if (sfr_wr_in && sfr_addr_in == 8'h8f) begin
         we_r <= sfr_wdata_in[0];
      end else if (sfr_wr_in && sfr_addr_in == 8'hb6) begin
         read_oneshot_enable_r <= sfr_wdata_in[7];
      end
   end
   assign mv = movx_wr_in && !busy_out && !dbg_req_in.req;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   property p_xram_route;
      mv && !we_r |=> xram_wr_out && xram_data_out == $past(movx_data_in);
   endproperty
   a_xram_route: assert property (p_xram_route)
      else $error("xram route");
   property p_flash_route;
      mv && we_r |=> !xram_wr_out;
   endproperty
   a_flash_route: assert property (p_flash_route)
      else $error("flash write leaked");
   property p_key_bits;
      sfr_rd_in && sfr_addr_in == 8'hb7 |=> sfr_rdata_out[7:2] == 6'h00;
   endproperty
   a_key_bits: assert property (p_key_bits)
      else $error("key upper bits");
   property p_sense_shot;
      $rose(flash_sense_out) && read_oneshot_enable_r
         |-> flash_sense_out[*3] ##1 !flash_sense_out;
   endproperty
   a_sense_shot: assert property (p_sense_shot)
      else $error("one-shot length");
   property p_sense_cyc;
      $rose(flash_sense_out) && !read_oneshot_enable_r |=> !flash_sense_out;
   endproperty
   a_sense_cyc: assert property (p_sense_cyc)
      else $error("sense not one cycle");
   property p_err_flag;
      flash_error_reset_out
         |-> flash_error_flag_out ##1 !flash_error_reset_out;
   endproperty
   a_err_flag: assert property (p_err_flag)
      else $error("error reset or flag");
   property p_req_hold;
      flash_req_out.req && !flash_done_in |=> $stable(flash_req_out);
   endproperty
   a_req_hold: assert property (p_req_hold)
      else $error("command not held");
   property p_erase_page;
      flash_req_out.req && flash_req_out.op == FWPS_OP_ERASE
         |-> flash_req_out.addr[8:0] == 9'h000;
   endproperty
   a_erase_page: assert property (p_erase_page)
      else $error("erase not aligned");
   property p_dbg_answer;
      dbg_req_in.req && !busy_out |-> ##[1:400] dbg_rsp_out.done;
   endproperty
   a_dbg_answer: assert property (p_dbg_answer)
      else $error("debug unanswered");
   property p_boot_lock;
      $fell(rst_in) |-> ##[0:2] flash_req_out.req
         && flash_req_out.addr == 13'h1dff;
   endproperty
   a_boot_lock: assert property (p_boot_lock)
      else $error("no lock fetch");

   c_dbg_ok: cover property (dbg_rsp_out.done && dbg_rsp_out.ok);
   c_err: cover property (flash_error_reset_out);
   c_erase: cover property (flash_req_out.req
      && flash_req_out.op == FWPS_OP_ERASE);
endmodule // fwps_chk

bind fwps_top fwps_chk chk_u (.*);

//--- fwps_top_tb.sv
// Self-checking bench for the flash protect controller.
// Assumes the flash model answers commands; inputs change at falling edges.
`timescale 1ns/1ns

module fwps_top_tb import fwps_pkg::*;;
   logic clk_in, rst_in, sfr_wr_in, sfr_rd_in, movx_wr_in, code_rd_in;
   logic [7:0] sfr_addr_in, sfr_wdata_in, movx_data_in, sfr_rdata_out;
   logic [12:0] movx_addr_in, code_addr_in, exec_pc_in, xram_addr_out;
   logic xram_wr_out, cpu_done_out, busy_out, flash_done_in;
   logic flash_sense_out, flash_error_reset_out, flash_error_flag_out;
   logic [7:0] xram_data_out, code_rdata_out, flash_rdata_in, rd;
   logic [3:0] dly;
   logic err;
   fwps_dbg_req_t dbg_req_in;
   fwps_dbg_rsp_t dbg_rsp_out;
   fwps_flash_req_t flash_req_out;
   int fails, n_tests;

   fwps_top dut_u (.*);
   fwps_flash_model flash_u (.clk_in(clk_in), .dly_in(dly),
      .req_in(flash_req_out), .done_out(flash_done_in),
      .rdata_out(flash_rdata_in));

   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic idle;
      for (int i = 0; i < 300 && busy_out !== 1'b0; i++) @(negedge clk_in);
   endtask
   task automatic boot;
      rst_in = 1'b1;
      repeat (5) @(negedge clk_in);
      rst_in = 1'b0;
      @(negedge clk_in);
      idle();
   endtask
   task automatic sfr(input logic [7:0] a, d, input logic wr = 1'b1);
      @(negedge clk_in);
      sfr_wr_in = wr;
      sfr_rd_in = !wr;
      sfr_addr_in = a;
      sfr_wdata_in = d;
      @(negedge clk_in);
      sfr_wr_in = 1'b0;
      sfr_rd_in = 1'b0;
      rd = sfr_rdata_out;
   endtask
   task automatic rc(input logic [7:0] a, e);
      sfr(a, 8'h00, 1'b0);
      check(rd, e);
   endtask
   task automatic key;
      sfr(8'hb7, 8'ha5);
      sfr(8'hb7, 8'hf1);
   endtask
   task automatic cpu(input logic [12:0] a, input logic [7:0] d,
                      input logic rdop = 1'b0);
      idle();
      movx_wr_in = !rdop;
      code_rd_in = rdop;
      movx_addr_in = a;
      code_addr_in = a;
      movx_data_in = d;
      @(negedge clk_in);
      movx_wr_in = 1'b0;
      code_rd_in = 1'b0;
      movx_data_in = ~d;
      for (int i = 0; i < 300 && !(cpu_done_out | xram_wr_out
           | flash_error_reset_out); i++) @(negedge clk_in);
      err = flash_error_reset_out;
      rd = code_rdata_out;
   endtask
   task automatic dbg(input fwps_dbg_cmd_t c, input logic [12:0] a,
                      input logic [7:0] d, input logic ok);
      idle();
      dbg_req_in = '{1'b1, c, a, d};
      @(negedge clk_in);
      dbg_req_in = '{1'b0, c, ~a, ~d};
      for (int i = 0; i < 300 && dbg_rsp_out.done !== 1'b1; i++)
         @(negedge clk_in);
      check(8'(dbg_rsp_out.ok), 8'(ok));
      rd = dbg_rsp_out.data;
   endtask

   initial begin
      repeat (20000) @(posedge clk_in);
      fails++;
      wrap_up();
   end

   initial begin
      {rst_in, sfr_wr_in, sfr_rd_in, movx_wr_in, code_rd_in} = 5'h10;
      {sfr_addr_in, sfr_wdata_in, movx_data_in} = 24'h000000;
      {movx_addr_in, code_addr_in} = 26'h0000000;
      exec_pc_in = 13'h1000;
      dbg_req_in = '0;
      dly = 4'h1;
      boot();
      rc(8'h8f, 8'h00);
      rc(8'hb6, 8'h80);
      rc(8'hb7, 8'h00);
      rc(8'h10, 8'h00);
      sfr(8'hb6, 8'h7f); rc(8'hb6, 8'h00);
      cpu(13'h0000, 8'h00, 1'b1); check(rd, 8'hff);
      sfr(8'hb6, 8'hff); rc(8'hb6, 8'h80);
      sfr(8'h8f, 8'hfe); rc(8'h8f, 8'h02);
      cpu(13'h0123, 8'h5a); check(xram_data_out, 8'h5a);
      check(xram_addr_out[7:0], 8'h23);
      sfr(8'h8f, 8'h01);
      sfr(8'hb7, 8'ha5); rc(8'hb7, 8'h01);
      sfr(8'hb7, 8'hf1); rc(8'hb7, 8'h02);
      dly = 4'h7;
      cpu(13'h0100, 8'h3c); check(8'(err), 8'h00);
      rc(8'hb7, 8'h00);
      rc(8'h8f, 8'h01);
      cpu(13'h0100, 8'h00, 1'b1); check(rd, 8'h3c);
      key();
      cpu(13'h0100, 8'hf0);
      cpu(13'h0100, 8'h00, 1'b1); check(rd, 8'h30);
      sfr(8'h8f, 8'h03); key();
      cpu(13'h0105, 8'h00);
      cpu(13'h0100, 8'h00, 1'b1); check(rd, 8'hff);
      dly = 4'h1;
      dbg(FWPS_DBG_WRITE, 13'h0200, 8'h55, 1'b1);
      dbg(FWPS_DBG_READ, 13'h0200, 8'h00, 1'b1); check(rd, 8'h55);
      sfr(8'h8f, 8'h01); sfr(8'hb7, 8'ha5); sfr(8'hb7, 8'h00);
      rc(8'hb7, 8'h03);
      key(); rc(8'hb7, 8'h03);
      cpu(13'h0200, 8'h00);
      cpu(13'h0200, 8'h00, 1'b1); check(rd, 8'h55);
      boot(); sfr(8'h8f, 8'h01);
      cpu(13'h0200, 8'h00);
      rc(8'hb7, 8'h03);
      cpu(13'h0200, 8'h00, 1'b1); check(rd, 8'h55);
      boot(); sfr(8'h8f, 8'h01); key();
      cpu(13'h1dff, 8'hfe);
      boot();
      dbg(FWPS_DBG_READ, 13'h0200, 8'h00, 1'b0);
      dbg(FWPS_DBG_READ, 13'h1dff, 8'h00, 1'b0);
      dbg(FWPS_DBG_WRITE, 13'h1000, 8'h00, 1'b0);
      dbg(FWPS_DBG_ERASE, 13'h1000, 8'h00, 1'b0);
      cpu(13'h1dff, 8'h00, 1'b1); check(rd, 8'hfe);
      cpu(13'h0200, 8'h00, 1'b1); check(8'(err), 8'h01);
      check(8'(flash_error_flag_out), 8'h01);
      boot(); exec_pc_in = 13'h0000;
      cpu(13'h0200, 8'h00, 1'b1); check(rd, 8'h55);
      sfr(8'h8f, 8'h03); key();
      cpu(13'h1c00, 8'h00); check(8'(err), 8'h01);
      boot();
      cpu(13'h1e00, 8'h00, 1'b1); check(8'(err), 8'h01);
      boot();
      dbg(FWPS_DBG_DEV_ERASE, 13'h0000, 8'h00, 1'b1);
      boot();
      dbg(FWPS_DBG_READ, 13'h0200, 8'h00, 1'b1); check(rd, 8'hff);
      wrap_up();
   end
endmodule // fwps_top_tb
